// *** rtl/core_pkg.sv ***
/*
 * shared constants for the stack and indirect pointer core logic.
 * assumes a single instruction clock; every figure here is used by the rtl.
 */
package core_pkg;
    localparam int PC_W = 15;                    // return address width
    localparam int STACK_DEPTH = 16;             // hardware stack entries
    localparam int STACK_PTR_W = 5;              // holds 0..16 occupied count
    localparam int PTR_W = 16;                   // indirect pointer width
    localparam int DATA_W = 8;                   // data path width
    localparam int CTX_W = 8;                    // width of one saved context register
    localparam int CTX_N = 4;                    // number of shadowed core registers
    localparam int NUM_INSTR = 49;               // distinct instructions decoded
    localparam int OPC_W = 6;                    // instruction select code width
    localparam logic [PC_W-1:0] RESET_VEC = 15'h0000;
    localparam logic [PC_W-1:0] IRQ_VEC = 15'h0004;
    localparam int PROG_SEL_BIT = 15;            // pointer bit that selects program memory
    localparam logic [PTR_W-1:0] LINEAR_BASE = 16'h2000; // start of linear ram window
    localparam int BANK_GPR = 80;                // gpr bytes per bank
    localparam int BANK_SIZE = 128;              // bytes per bank
    localparam logic [6:0] GPR_OFS = 7'h20;      // first gpr byte in a bank
    localparam int POWER_CONTROL_REGISTER_OVF_BIT = 7;             // overflow flag position
    localparam int POWER_CONTROL_REGISTER_UNF_BIT = 6;             // underflow flag position
    localparam logic [DATA_W-1:0] POWER_CONTROL_REGISTER_RESET = 8'h00;
    localparam logic [PTR_W-1:0] PTR_RESET = 16'h0000;

    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_DATA = 2'b01,
        ACC_PROG1 = 2'b10,
        ACC_PROG2 = 2'b11
    } acc_state_t;
endpackage : core_pkg

// *** rtl/linear_map.sv ***
/*
 * maps a pointer value onto a banked data address or a program address.
 * assumes the caller only acts on the outputs in the same cycle.
 */
`timescale 1ns/1ns
module linear_map (
    input wire logic [core_pkg::PTR_W-1:0] ptr_in,  // pointer value
    output logic is_prog_out,                       // pointer aims at program memory
    output logic [core_pkg::PC_W-1:0] prog_addr_out, // program word address
    output logic [12:0] data_addr_out               // banked data address
);
    import core_pkg::*;

    logic [12:0] lin_ofs;
    logic [12:0] bank_num;
    logic [12:0] bank_pos;

    // linear window folds 80-byte gpr chunks into successive banks
    always_comb begin
        lin_ofs = ptr_in[12:0];
        bank_num = lin_ofs / 13'(BANK_GPR);
        bank_pos = lin_ofs - bank_num * 13'(BANK_GPR);
        is_prog_out = ptr_in[PROG_SEL_BIT];
        prog_addr_out = ptr_in[PC_W-1:0];
        if (ptr_in[15:13] == LINEAR_BASE[15:13]) begin
            data_addr_out = 13'(bank_num * 13'(BANK_SIZE) + 13'(GPR_OFS) + bank_pos);
        end else begin
            data_addr_out = ptr_in[12:0];
        end
    end
endmodule : linear_map

// *** rtl/cpu_stack_and_indirect_core.sv ***
/*
 * return stack, interrupt shadow registers and the two indirect pointers.
 * assumes the sequencer issues one push/pop/access request per cycle and
 * holds the instruction while stall_out is high.
 */
`timescale 1ns/1ns
// Contract
// - separate return stack of 16 entries, 15 bits each
// - overflow and underflow set their flags in the power control register
// - with stack reset enabled, overflow or underflow causes a software reset
// - interrupt entry copies core registers to shadows; return restores them
// - two 16-bit pointers reach all file registers and program memory
// - indirect access to program memory costs one extra instruction cycle
// - general ram is addressable linearly across banks through the pointers
// - the decoder accepts 49 distinct instructions
// - interrupt pushes return address and loads pc with 0004h
module cpu_stack_and_indirect_core (
    input wire logic sys_clk_in,                          // instruction clock
    input wire logic rst_b_in,                            // sync reset, active low
    input wire logic [core_pkg::OPC_W-1:0] opcode_in,     // decoded instruction number
    input wire logic call_in,                             // push pc (call)
    input wire logic ret_in,                              // pop to pc (return)
    input wire logic irq_in,                              // interrupt entry
    input wire logic retfie_in,                           // interrupt return
    input wire logic [core_pkg::PC_W-1:0] pc_in,          // return address to push
    input wire logic stack_reset_en_in,                   // stack error reset enable
    input wire logic power_control_register_clr_in,                         // clear both stack flags
    input wire logic [core_pkg::CTX_N*core_pkg::CTX_W-1:0] ctx_in, // live core registers
    input wire logic ptr_wr_in,                           // write a pointer
    input wire logic ptr_sel_in,                          // which pointer
    input wire logic [core_pkg::PTR_W-1:0] ptr_wdata_in,  // pointer write value
    input wire logic ind_acc_in,                          // access through data port
    input wire logic [13:0] prog_word_in,                 // program word fetched
    input wire logic [core_pkg::DATA_W-1:0] data_rd_in,   // data memory read value
    output logic [core_pkg::PC_W-1:0] pc_load_out,        // new pc value
    output logic pc_load_en_out,                          // load pc this cycle
    output logic [core_pkg::CTX_N*core_pkg::CTX_W-1:0] ctx_out, // restored registers
    output logic ctx_restore_out,                         // restore strobe
    output logic [core_pkg::DATA_W-1:0] power_control_register_out,         // power control register
    output logic soft_reset_out,                          // software reset request
    output logic illegal_op_out,                          // opcode not in set
    output logic [core_pkg::PTR_W-1:0] ptr0_out,          // pointer 0
    output logic [core_pkg::PTR_W-1:0] ptr1_out,          // pointer 1
    output logic stall_out,                               // extra cycle in progress
    output logic prog_rd_out,                             // program fetch request
    output logic [core_pkg::PC_W-1:0] prog_addr_out,      // program fetch address
    output logic [12:0] data_addr_out,                    // data memory address
    output logic [core_pkg::DATA_W-1:0] ind_data_out,     // indirect read data
    output logic ind_valid_out                            // indirect data ready
);
    import core_pkg::*;

    logic [PC_W-1:0] stack_mem [STACK_DEPTH];
    logic [STACK_PTR_W-1:0] depth_reg;
    logic push_req;
    logic pop_req;
    logic ovf_ev;
    logic unf_ev;
    logic [DATA_W-1:0] power_control_register_reg;
    logic [CTX_N*CTX_W-1:0] shadow_reg;
    logic [PTR_W-1:0] ptr_reg [2];
    acc_state_t acc_reg;
    acc_state_t acc_next;
    logic [PTR_W-1:0] cur_ptr;
    logic cur_is_prog;
    logic [PC_W-1:0] map_prog_addr;
    logic [12:0] map_data_addr;

    function automatic logic full_chk(input logic [STACK_PTR_W-1:0] d);
        full_chk = (d == STACK_PTR_W'(STACK_DEPTH));
    endfunction : full_chk

    // interrupt entry pushes like a call, returns pop like a return
    assign push_req = call_in | irq_in;
    assign pop_req = ret_in | retfie_in;
    assign ovf_ev = push_req & full_chk(depth_reg);
    // a pop dropped in favour of a push is no underflow
    assign unf_ev = pop_req & !push_req & (depth_reg == '0);

    // stack storage kept apart from data memory; errors do not move depth
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            depth_reg <= '0;
        end else if (push_req && !ovf_ev) begin
            stack_mem[depth_reg[3:0]] <= pc_in;
            depth_reg <= depth_reg + 1'b1;
        end else if (pop_req && !push_req && !unf_ev) begin
            depth_reg <= depth_reg - 1'b1;
        end
    end

    // pc load: vector on interrupt, top of stack on return
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            pc_load_out <= RESET_VEC;
            pc_load_en_out <= 1'b0;
        end else if (irq_in) begin
            pc_load_out <= IRQ_VEC;
            pc_load_en_out <= 1'b1;
        end else if (pop_req && !push_req && !unf_ev) begin
            pc_load_out <= stack_mem[4'(depth_reg - 1'b1)];
            pc_load_en_out <= 1'b1;
        end else begin
            pc_load_en_out <= 1'b0;
        end
    end

    // sticky flags; a new error wins over a clear in the same cycle
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            power_control_register_reg <= POWER_CONTROL_REGISTER_RESET;
        end else begin
            if (ovf_ev) begin
                power_control_register_reg[POWER_CONTROL_REGISTER_OVF_BIT] <= 1'b1;
            end else if (power_control_register_clr_in) begin
                power_control_register_reg[POWER_CONTROL_REGISTER_OVF_BIT] <= 1'b0;
            end
            if (unf_ev) begin
                power_control_register_reg[POWER_CONTROL_REGISTER_UNF_BIT] <= 1'b1;
            end else if (power_control_register_clr_in) begin
                power_control_register_reg[POWER_CONTROL_REGISTER_UNF_BIT] <= 1'b0;
            end
        end
    end
    assign power_control_register_out = power_control_register_reg;

    // reset request registered so it is a clean one-cycle pulse
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            soft_reset_out <= 1'b0;
        end else begin
            soft_reset_out <= stack_reset_en_in & (ovf_ev | unf_ev);
        end
    end

    // shadows need no stack slots, so context survives deep call chains
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            shadow_reg <= '0;
            ctx_restore_out <= 1'b0;
        end else begin
            if (irq_in) begin
                shadow_reg <= ctx_in;
            end
            ctx_restore_out <= retfie_in;
        end
    end
    assign ctx_out = shadow_reg;

    // opcode range check against the instruction set size
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            illegal_op_out <= 1'b0;
        end else begin
            illegal_op_out <= (opcode_in >= OPC_W'(NUM_INSTR));
        end
    end

    // pointer registers, both full width
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            ptr_reg[0] <= PTR_RESET;
            ptr_reg[1] <= PTR_RESET;
        end else if (ptr_wr_in) begin
            ptr_reg[ptr_sel_in] <= ptr_wdata_in;
        end
    end
    assign ptr0_out = ptr_reg[0];
    assign ptr1_out = ptr_reg[1];
    assign cur_ptr = ptr_reg[ptr_sel_in];

    linear_map u_map (
        .ptr_in(cur_ptr),
        .is_prog_out(cur_is_prog),
        .prog_addr_out(map_prog_addr),
        .data_addr_out(map_data_addr)
    );

    // indirect access sequencing; program reads hold for a second cycle
    always_comb begin
        acc_next = ACC_IDLE;
        case (acc_reg)
            ACC_IDLE: begin
                if (ind_acc_in) begin
                    acc_next = cur_is_prog ? ACC_PROG1 : ACC_DATA;
                end
            end
            ACC_PROG1: acc_next = ACC_PROG2;
            ACC_DATA: acc_next = ACC_IDLE;
            ACC_PROG2: acc_next = ACC_IDLE;
            default: acc_next = ACC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            acc_reg <= ACC_IDLE;
        end else begin
            acc_reg <= acc_next;
        end
    end

    // the stall covers the extra fetch cycle of a program access
    assign stall_out = (acc_reg == ACC_PROG1);
    assign prog_rd_out = (acc_reg == ACC_PROG1);

    // addresses and read data registered; program reads give the low byte
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            prog_addr_out <= RESET_VEC;
            data_addr_out <= '0;
            ind_data_out <= '0;
            ind_valid_out <= 1'b0;
        end else begin
            if (ind_acc_in && acc_reg == ACC_IDLE) begin
                prog_addr_out <= map_prog_addr;
                data_addr_out <= map_data_addr;
            end
            ind_valid_out <= (acc_reg == ACC_DATA) || (acc_reg == ACC_PROG2);
            if (acc_reg == ACC_DATA) begin
                ind_data_out <= data_rd_in;
            end else if (acc_reg == ACC_PROG2) begin
                ind_data_out <= prog_word_in[DATA_W-1:0];
            end
        end
    end
endmodule : cpu_stack_and_indirect_core

// *** dv/core_props.sv ***
/*
 * concurrent checks on the stack, shadow and pointer core ports.
 * assumes one clock and the synchronous active-low reset of the core.
 */
`timescale 1ns/1ns
module core_props (
    input wire logic sys_clk_in,                      // clock
    input wire logic rst_b_in,                        // reset
    input wire logic [core_pkg::OPC_W-1:0] opcode_in, // opcode
    input wire logic call_in,                         // push
    input wire logic ret_in,                          // pop
    input wire logic irq_in,                          // irq push
    input wire logic retfie_in,                       // irq pop
    input wire logic stack_reset_en_in,               // error reset enable
    input wire logic power_control_register_clr_in,                     // flag clear
    input wire logic ind_acc_in,                      // indirect access
    input wire logic [core_pkg::PC_W-1:0] pc_load_out, // pc value
    input wire logic pc_load_en_out,                  // pc strobe
    input wire logic ctx_restore_out,                 // restore strobe
    input wire logic [core_pkg::DATA_W-1:0] power_control_register_out, // flags
    input wire logic soft_reset_out,                  // soft reset
    input wire logic illegal_op_out,                  // bad opcode
    input wire logic stall_out,                       // extra cycle
    input wire logic prog_rd_out,                     // program fetch
    input wire logic ind_valid_out                    // indirect data
);
    import core_pkg::*;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    logic [4:0] depth_reg;
    logic push, pop;
    assign push = call_in || irq_in;
    assign pop = (ret_in || retfie_in) && !push;
    // stack occupancy count; a refused push or pop leaves it alone
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) depth_reg <= 5'h00;
        else if (push && depth_reg != 5'h10) depth_reg <= depth_reg + 5'h01;
        else if (pop && depth_reg != 5'h00) depth_reg <= depth_reg - 5'h01;
    end
    a_irq_vector: assert property (pc_load_en_out && $past(irq_in) |-> pc_load_out == IRQ_VEC)
        else $error("pc not loaded with interrupt vector");
    a_pop_loads: assert property (pop && depth_reg != 5'h00 |=> pc_load_en_out)
        else $error("pop with entries did not load pc");
    a_empty_pop: assert property (pop && depth_reg == 5'h00 |=> !pc_load_en_out && power_control_register_out[6])
        else $error("pop on empty stack mishandled");
    a_full_push: assert property (push && depth_reg == 5'h10 |=> power_control_register_out[7])
        else $error("push on full stack did not flag");
    a_flag_sticky: assert property (power_control_register_out[7] && !power_control_register_clr_in |=> power_control_register_out[7])
        else $error("overflow flag dropped");
    a_soft_cause: assert property (soft_reset_out |-> $past(stack_reset_en_in) && power_control_register_out[7:6] != 2'b00)
        else $error("soft reset without enabled stack error");
    a_ctx_restore: assert property (retfie_in |=> ctx_restore_out)
        else $error("no restore strobe after interrupt return");
    a_valid_cause: assert property (ind_valid_out |-> $past(ind_acc_in, 2) || $past(ind_acc_in, 3))
        else $error("indirect data without request");
    a_prog_stall: assert property ($rose(stall_out) |-> prog_rd_out ##1 !stall_out ##1 ind_valid_out)
        else $error("program access not one extra cycle");
    a_illegal_op: assert property ($past(rst_b_in) |-> illegal_op_out == ($past(opcode_in) >= NUM_INSTR))
        else $error("illegal opcode flag wrong");
endmodule : core_props

bind cpu_stack_and_indirect_core core_props i_props (.*);

// *** dv/cpu_stack_and_indirect_core_bench.sv ***
/*
 * self-checking bench for the stack, shadow and pointer core.
 * assumes the core package and design are compiled first; no partner model.
 */
`timescale 1ns/1ns
module cpu_stack_and_indirect_core_bench;
    import core_pkg::*;
    logic sys_clk_in = 1'b0, rst_b_in = 1'b0;
    logic [OPC_W-1:0] opcode_in = '0;
    logic call_in = 0, ret_in = 0, irq_in = 0, retfie_in = 0, stack_reset_en_in = 0;
    logic power_control_register_clr_in = 0, ptr_wr_in = 0, ptr_sel_in = 0, ind_acc_in = 0;
    logic [PC_W-1:0] pc_in = '0, pc_load_out, prog_addr_out;
    logic [CTX_N*CTX_W-1:0] ctx_in = '0, ctx_out;
    logic [PTR_W-1:0] ptr_wdata_in = '0, ptr0_out, ptr1_out;
    logic [13:0] prog_word_in = '0;
    logic [12:0] data_addr_out;
    logic [DATA_W-1:0] data_rd_in = '0, power_control_register_out, ind_data_out;
    logic pc_load_en_out, ctx_restore_out, soft_reset_out, illegal_op_out;
    logic stall_out, prog_rd_out, ind_valid_out;
    logic [31:0] exp_q[$];
    int errors = 0, check_count = 0;
    cpu_stack_and_indirect_core i_dut (.*);
    // free running clock
    always #5 sys_clk_in = ~sys_clk_in;
    task automatic tick();
        @(posedge sys_clk_in);
        #1;
    endtask : tick
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check
    // a result with no note behind it is a spurious strobe
    task automatic take(string name, logic [31:0] seen);
        if (exp_q.size() == 0) begin
            errors++;
            $display("wrong value %s expected none seen %0h", name, seen);
        end else check(name, seen, exp_q.pop_front());
    endtask : take
    task automatic test_done();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done
    // watcher: strobes are sampled mid-cycle, well after they settle
    always @(negedge sys_clk_in) begin
        if (rst_b_in && pc_load_en_out) take("pc_load", 32'(pc_load_out));
        if (rst_b_in && ctx_restore_out) take("ctx", ctx_out);
        if (rst_b_in && ind_valid_out) take("ind_data", 32'(ind_data_out));
    end
    // the whole run needs under a hundred cycles, so this is a wide margin
    initial begin
        #50000;
        errors++;
        test_done();
    end
    // main sequence
    initial begin
        logic [PC_W-1:0] pcs[16];
        logic [31:0] ctx_v;
        logic [14:0] w_a;
        void'($urandom(59));
        repeat (20) tick();
        rst_b_in = 1'b1;
        for (int i = 46; i < 52; i++) begin
            opcode_in = 6'(i);
            tick();
            check("illegal_op", 32'(illegal_op_out), 32'(i >= NUM_INSTR));
        end
        // interrupt entry then return restores the shadows
        pc_in = 15'($urandom);
        ctx_v = $urandom;
        ctx_in = ctx_v;
        irq_in = 1;
        exp_q.push_back(32'(IRQ_VEC));
        tick();
        irq_in = 0;
        ctx_in = ~ctx_v;
        retfie_in = 1;
        exp_q.push_back(32'(pc_in));
        exp_q.push_back(ctx_v);
        tick();
        retfie_in = 0;
        // sixteen back-to-back calls, then one too many
        call_in = 1;
        for (int i = 0; i < 16; i++) begin
            pcs[i] = 15'($urandom);
            pc_in = pcs[i];
            tick();
        end
        pc_in = ~pcs[15];
        tick();
        call_in = 0;
        check("overflow", 32'(power_control_register_out[7]), 32'h1);
        ret_in = 1;
        for (int i = 15; i >= 0; i--) begin
            exp_q.push_back(32'(pcs[i]));
            tick();
        end
        tick();
        ret_in = 0;
        check("power_control_register", 32'(power_control_register_out), 32'h000000C0);
        check("soft_reset", 32'(soft_reset_out), 32'h0);
        power_control_register_clr_in = 1;
        tick();
        power_control_register_clr_in = 0;
        check("power_control_register_clr", 32'(power_control_register_out), 32'h0);
        // pointer 0 into the linear window, pointer 1 at program memory
        w_a = 15'($urandom);
        ptr_wr_in = 1;
        ptr_wdata_in = LINEAR_BASE + 16'h0055;
        tick();
        ptr_sel_in = 1;
        ptr_wdata_in = {1'b1, w_a};
        tick();
        ptr_wr_in = 0;
        check("ptr0", 32'(ptr0_out), 32'h00002055);
        check("ptr1", 32'(ptr1_out), 32'({1'b1, w_a}));
        data_rd_in = 8'($urandom);
        prog_word_in = 14'($urandom);
        ptr_sel_in = 0;
        ind_acc_in = 1;
        exp_q.push_back(32'(data_rd_in));
        tick();
        ind_acc_in = 0;
        check("data_addr", 32'(data_addr_out), 32'h000000A5);
        repeat (3) tick();
        ptr_sel_in = 1;
        ind_acc_in = 1;
        exp_q.push_back(32'(prog_word_in[7:0]));
        tick();
        ind_acc_in = 0;
        check("stall", 32'(stall_out), 32'h1);
        check("prog_addr", 32'(prog_addr_out), 32'(w_a));
        repeat (4) tick();
        // stack error with reset enabled, then a device reset
        stack_reset_en_in = 1;
        ret_in = 1;
        power_control_register_clr_in = 1;
        tick();
        ret_in = 0;
        power_control_register_clr_in = 0;
        check("soft_reset", 32'(soft_reset_out), 32'h1);
        check("power_control_register_set_wins", 32'(power_control_register_out), 32'h00000040);
        // let the pulse be seen with reset high before the device reset
        tick();
        check("soft_pulse", 32'(soft_reset_out), 32'h0);
        rst_b_in = 0;
        repeat (2) tick();
        rst_b_in = 1;
        check("power_control_register_rst", 32'(power_control_register_out), 32'(POWER_CONTROL_REGISTER_RESET));
        check("ptr_rst", 32'(ptr1_out), 32'(PTR_RESET));
        tick();
        check("notes_left", 32'(exp_q.size()), 32'h0);
        test_done();
    end
endmodule : cpu_stack_and_indirect_core_bench
